// ### gsc_pkg.sv
// Purpose: shared constants for the receiver host-side serial control
// Assumes: 50 MHz sys_clk
// Notes:   counts derive from times and clock rate
package gsc_pkg;
  localparam int CLK_HZ         = 50_000_000;
  localparam int PPS_PERIOD_MS  = 1000;
  localparam int PPS_WIDTH_MS   = 100;
  localparam int PPS_PERIOD_CYC = CLK_HZ / 1000 * PPS_PERIOD_MS;
  localparam int PPS_WIDTH_CYC  = CLK_HZ / 1000 * PPS_WIDTH_MS;
  localparam int BAUD_4800      = 4800;
  localparam int BAUD_9600      = 9600;
  localparam int BAUD_38400     = 38400;
  localparam int BAUD_115200    = 115200;
  localparam int DIV_4800       = CLK_HZ / BAUD_4800;
  localparam int DIV_9600       = CLK_HZ / BAUD_9600;
  localparam int DIV_38400      = CLK_HZ / BAUD_38400;
  localparam int DIV_115200     = CLK_HZ / BAUD_115200;
  localparam int HOT_OUTAGE_SEC = 7200;
  localparam int DIV_W          = 16;
  localparam int PPS_W          = 26;
  localparam int SEC_W          = 16;
  localparam int DATA_BITS      = 8;
  localparam int FRAME_BITS     = 10;
  // pin sync reset: {high strap, low strap, backup ok, supply low, reset pin}
  localparam logic [4:0] PIN_SYNC_RST = 5'h19;
  localparam logic [7:0] CH_DOLLAR    = 8'h24;
  localparam logic [7:0] CH_STAR      = 8'h2A;
  localparam logic [7:0] CH_CR        = 8'h0D;
  localparam logic [7:0] CH_LF        = 8'h0A;
  localparam logic [7:0] CH_ZERO      = 8'h30;
  localparam logic [7:0] CH_ALPHA_OFS = 8'h37;

  typedef enum logic [1:0] {
    START_COLD = 2'h0,
    START_WARM = 2'h1,
    START_HOT  = 2'h2
  } gsc_start_e;

  typedef enum logic [2:0] {
    FR_IDLE  = 3'h0,
    FR_HEAD  = 3'h1,
    FR_BODY  = 3'h3,
    FR_STAR  = 3'h2,
    FR_SUMHI = 3'h6,
    FR_SUMLO = 3'h7,
    FR_CR    = 3'h5,
    FR_LF    = 3'h4
  } gsc_frame_e;
endpackage

// ### gsc_uart_rx.sv
// Purpose: 8N1 serial receiver with pin synchroniser
// Assumes: divisor stable while receiving
// Notes:   samples mid-bit, flags a bad stop bit
`timescale 1ns/1ps
`default_nettype none
module gsc_uart_rx (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic [gsc_pkg::DIV_W-1:0] divisor,
  input  wire logic                    serialIn,
  output logic      [7:0]              rxData,
  output logic                         rxValid,
  output logic                         frameErr
);
  logic                      inMeta;
  logic                      inSync;
  logic                      busy;
  logic [gsc_pkg::DIV_W-1:0] divCnt;
  logic [3:0]                bitCnt;
  logic [7:0]                shiftReg;
  wire                       sampleNow = busy && (divCnt == 16'h0);
  wire                       lastBit   = (bitCnt == 4'(gsc_pkg::DATA_BITS + 1));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      inMeta <= 1'b1;
      inSync <= 1'b1;
    end else begin
      inMeta <= serialIn;
      inSync <= inMeta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy     <= 1'b0;
      divCnt   <= 16'h0;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h0;
      rxData   <= 8'h0;
      rxValid  <= 1'b0;
      frameErr <= 1'b0;
    end else begin
      rxValid  <= 1'b0;
      frameErr <= 1'b0;
      if (!busy) begin
        if (!inSync) begin
          busy   <= 1'b1;
          divCnt <= divisor >> 1;
          bitCnt <= 4'h0;
        end
      end else if (!sampleNow) begin
        divCnt <= divCnt - 16'h1;
      end else begin
        divCnt <= divisor - 16'h1;
        bitCnt <= bitCnt + 4'h1;
        if (bitCnt == 4'h0) begin
          busy <= !inSync;
        end else if (!lastBit) begin
          shiftReg <= {inSync, shiftReg[7:1]};
        end else begin
          busy     <= 1'b0;
          rxData   <= shiftReg;
          rxValid  <= inSync;
          frameErr <= !inSync;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### gsc_host_serial_ctrl.sv
// Purpose: reset, strap, timing pulse, start mode and serial ports of the receiver
// Assumes: sys_clk keeps running from backup supply during outages
// Notes:   sentence payload comes from the navigation core
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE_01: reset pin held low fully resets the internal system; pin may float high.
// RULE_02: reset pin is input only and never driven by the device.
// RULE_03: main supply dropping below threshold forces internal reset.
// RULE_04: two straps pick 9600, 4800, 115200 or 38400 bit rate.
// RULE_05: primary port sends sentences, takes commands; secondary takes corrections.
// RULE_06: one timing pulse per second, rising edge marks second start.
// RULE_07: each timing pulse stays high exactly 100 ms.
// RULE_08: backup supply kept through outage gives hot or warm start by length.
// RULE_09: no backup supply means cold start at every power-up.
// RULE_10: sentences framed as dollar, payload, star, checksum, CR, LF.
// RULE_11: straps sampled once at reset release and held until next reset.
module gsc_host_serial_ctrl #(
  parameter int PPS_PERIOD_CYC = gsc_pkg::PPS_PERIOD_CYC,
  parameter int PPS_WIDTH_CYC  = gsc_pkg::PPS_WIDTH_CYC,
  parameter int DIV_4800       = gsc_pkg::DIV_4800,
  parameter int DIV_9600       = gsc_pkg::DIV_9600,
  parameter int HOT_OUTAGE_SEC = gsc_pkg::HOT_OUTAGE_SEC
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       resetPinN,
  input  wire logic       supplyLow,
  input  wire logic       backupSupplyOk,
  input  wire logic       baudHighStrap,
  input  wire logic       baudLowStrap,
  input  wire logic       primarySerialIn,
  input  wire logic       secondarySerialIn,
  output logic            primarySerialOut,
  input  wire logic [7:0] payloadData,
  input  wire logic       payloadValid,
  input  wire logic       payloadLast,
  output logic            payloadReady,
  output logic      [7:0] cmdData,
  output logic            cmdValid,
  output logic            cmdFrameErr,
  output logic      [7:0] rtcmData,
  output logic            rtcmValid,
  output logic            rtcmFrameErr,
  output logic            secondPulseOut,
  output logic            coreReset,
  output logic      [1:0] startMode,
  output logic            startValid,
  output logic      [1:0] baudSel
);
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and internal reset
  logic [4:0]                pinMeta;
  logic [4:0]                pinSync;
  logic                      sysRstDly;
  wire                       rstPinLow = !pinSync[0];
  wire                       supLow    = pinSync[1];
  wire                       backupOk  = pinSync[2];
  wire                       sysRst    = srst || rstPinLow || supLow; // see RULE_01 see RULE_03
  wire                       release_  = sysRstDly && !sysRst;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pinMeta <= gsc_pkg::PIN_SYNC_RST;
      pinSync <= gsc_pkg::PIN_SYNC_RST;
    end else begin
      pinMeta <= {baudHighStrap, baudLowStrap, backupSupplyOk, supplyLow, resetPinN};
      pinSync <= pinMeta;
    end
  end

  // reset pin only sampled, no driver exists for it (see RULE_02)
  always_ff @(posedge sys_clk) begin
    sysRstDly <= sysRst;
    coreReset <= sysRst;
  end

  //////////////////////////////////////////////////////////////////////////////
  // strap decode, captured at release
  logic [gsc_pkg::DIV_W-1:0] baudDiv;
  wire  [1:0]                strapCode = {!pinSync[4], !pinSync[3]};
  wire  [gsc_pkg::DIV_W-1:0] strapDiv  =
    (strapCode == 2'h0) ? gsc_pkg::DIV_W'(DIV_9600) :
    (strapCode == 2'h1) ? gsc_pkg::DIV_W'(DIV_4800) :
    (strapCode == 2'h2) ? gsc_pkg::DIV_W'(gsc_pkg::DIV_115200) :
                          gsc_pkg::DIV_W'(gsc_pkg::DIV_38400); // see RULE_04

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      baudSel <= 2'h0;
      baudDiv <= gsc_pkg::DIV_W'(DIV_9600);
    end else if (release_) begin
      baudSel <= strapCode; // see RULE_11
      baudDiv <= strapDiv;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // second pulse
  logic [gsc_pkg::PPS_W-1:0] ppsCnt;
  wire  [gsc_pkg::PPS_W-1:0] next_ppsCnt = (ppsCnt == gsc_pkg::PPS_W'(PPS_PERIOD_CYC - 1)) ?
                                           '0 : ppsCnt + 1'b1; // see RULE_06

  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      ppsCnt         <= gsc_pkg::PPS_W'(PPS_PERIOD_CYC - 1);
      secondPulseOut <= 1'b0;
    end else begin
      ppsCnt         <= next_ppsCnt;
      secondPulseOut <= (next_ppsCnt < gsc_pkg::PPS_W'(PPS_WIDTH_CYC)); // see RULE_07
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outage timing and start mode
  logic [gsc_pkg::PPS_W-1:0] outPre;
  logic [gsc_pkg::SEC_W-1:0] outSec;
  logic                      backupKept;
  wire                       outSecTick = (outPre == gsc_pkg::PPS_W'(PPS_PERIOD_CYC - 1));
  wire                       outShort   = (outSec <= gsc_pkg::SEC_W'(HOT_OUTAGE_SEC));
  wire  [1:0]                next_start = !backupKept ? gsc_pkg::START_COLD :
                                          outShort   ? gsc_pkg::START_HOT  :
                                                       gsc_pkg::START_WARM; // see RULE_08

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      outPre     <= '0;
      outSec     <= '0;
      backupKept <= 1'b0; // see RULE_09
      startMode  <= gsc_pkg::START_COLD;
      startValid <= 1'b0;
    end else begin
      startValid <= release_;
      if (release_) begin
        startMode  <= next_start;
        outPre     <= '0;
        outSec     <= '0;
        backupKept <= backupOk;
      end else if (supLow) begin
        outPre <= outSecTick ? '0 : outPre + 1'b1;
        if (outSecTick && outSec != '1) begin
          outSec <= outSec + 1'b1;
        end
        if (!backupOk) begin
          backupKept <= 1'b0; // see RULE_09
        end
      end else if (!sysRst) begin
        backupKept <= backupOk; // see RULE_08
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sentence framer
  gsc_pkg::gsc_frame_e       frState;
  gsc_pkg::gsc_frame_e       next_frState;
  logic [7:0]                checkSum;
  logic                      txBusy;
  logic [gsc_pkg::DIV_W-1:0] txDivCnt;
  logic [3:0]                txBitCnt;
  logic [9:0]                txShift;

  function automatic logic [7:0] hexChar(input logic [3:0] nib);
    hexChar = (nib < 4'hA) ? gsc_pkg::CH_ZERO + {4'h0, nib} : gsc_pkg::CH_ALPHA_OFS + {4'h0, nib};
  endfunction

  wire        txFree  = !txBusy && !sysRst;
  wire        isBody  = (frState == gsc_pkg::FR_BODY);
  wire        txLoad  = txFree && (frState != gsc_pkg::FR_IDLE) && (!isBody || payloadValid);
  wire [7:0]  txByte  =
    (frState == gsc_pkg::FR_HEAD)  ? gsc_pkg::CH_DOLLAR :
    (frState == gsc_pkg::FR_BODY)  ? payloadData :
    (frState == gsc_pkg::FR_STAR)  ? gsc_pkg::CH_STAR :
    (frState == gsc_pkg::FR_SUMHI) ? hexChar(checkSum[7:4]) :
    (frState == gsc_pkg::FR_SUMLO) ? hexChar(checkSum[3:0]) :
    (frState == gsc_pkg::FR_CR)    ? gsc_pkg::CH_CR : gsc_pkg::CH_LF; // see RULE_10

  assign payloadReady = txFree && isBody; // see RULE_05

  always_comb begin
    next_frState = frState;
    case (frState)
      gsc_pkg::FR_IDLE:  if (payloadValid && !sysRst) next_frState = gsc_pkg::FR_HEAD;
      gsc_pkg::FR_HEAD:  if (txLoad) next_frState = gsc_pkg::FR_BODY;
      gsc_pkg::FR_BODY:  if (txLoad && payloadLast) next_frState = gsc_pkg::FR_STAR;
      gsc_pkg::FR_STAR:  if (txLoad) next_frState = gsc_pkg::FR_SUMHI;
      gsc_pkg::FR_SUMHI: if (txLoad) next_frState = gsc_pkg::FR_SUMLO;
      gsc_pkg::FR_SUMLO: if (txLoad) next_frState = gsc_pkg::FR_CR;
      gsc_pkg::FR_CR:    if (txLoad) next_frState = gsc_pkg::FR_LF;
      gsc_pkg::FR_LF:    if (txLoad) next_frState = gsc_pkg::FR_IDLE;
      default:           next_frState = gsc_pkg::FR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      frState  <= gsc_pkg::FR_IDLE;
      checkSum <= 8'h0;
    end else begin
      frState <= next_frState;
      if (frState == gsc_pkg::FR_HEAD) begin
        checkSum <= 8'h0;
      end else if (isBody && txLoad) begin
        checkSum <= checkSum ^ payloadData; // see RULE_10
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // primary serial transmitter, 8N1
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      txBusy           <= 1'b0;
      txDivCnt         <= '0;
      txBitCnt         <= 4'h0;
      txShift          <= 10'h3FF;
      primarySerialOut <= 1'b1;
    end else begin
      primarySerialOut <= txBusy ? txShift[0] : 1'b1;
      if (txLoad) begin
        txBusy   <= 1'b1;
        txShift  <= {1'b1, txByte, 1'b0};
        txDivCnt <= baudDiv - 1'b1;
        txBitCnt <= 4'h0;
      end else if (txBusy) begin
        if (txDivCnt != '0) begin
          txDivCnt <= txDivCnt - 1'b1;
        end else begin
          txDivCnt <= baudDiv - 1'b1;
          txShift  <= {1'b1, txShift[9:1]};
          txBitCnt <= txBitCnt + 4'h1;
          txBusy   <= (txBitCnt != 4'(gsc_pkg::FRAME_BITS - 1));
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receivers: commands on primary, corrections on secondary (see RULE_05)
  gsc_uart_rx u_cmd_rx (
    .sys_clk  (sys_clk),
    .srst     (sysRst),
    .divisor  (baudDiv),
    .serialIn (primarySerialIn),
    .rxData   (cmdData),
    .rxValid  (cmdValid),
    .frameErr (cmdFrameErr)
  );

  gsc_uart_rx u_rtcm_rx (
    .sys_clk  (sys_clk),
    .srst     (sysRst),
    .divisor  (baudDiv),
    .serialIn (secondarySerialIn),
    .rxData   (rtcmData),
    .rxValid  (rtcmValid),
    .frameErr (rtcmFrameErr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence relSeq;
    $fell(sysRst);
  endsequence

  chk_reset_pin: assert property (rstPinLow |=> coreReset && !secondPulseOut) // see RULE_01
    else $error("reset pin low did not reset core");
  chk_supply_drop: assert property (supLow |=> coreReset && frState == gsc_pkg::FR_IDLE) // see RULE_03
    else $error("supply drop did not force reset");
  chk_strap_fast: assert property (relSeq and (strapCode == 2'h3)
                                   |=> baudDiv == gsc_pkg::DIV_W'(gsc_pkg::DIV_38400)) // see RULE_04
    else $error("both straps low must give 38400");
  chk_strap_hold: assert property (!sysRst && !$past(sysRst) && !$past(sysRst, 2)
                                   |-> $stable(baudDiv)) // see RULE_11
    else $error("bit rate changed outside release");
  chk_pps_rise: assert property ($rose(secondPulseOut) |-> ppsCnt == '0) // see RULE_06
    else $error("second pulse not at second start");
  chk_pps_width: assert property ($fell(secondPulseOut) && !sysRst
                                  |-> ppsCnt == gsc_pkg::PPS_W'(PPS_WIDTH_CYC)) // see RULE_07
    else $error("second pulse width wrong");
  chk_cold_start: assert property (relSeq and !backupKept |=> startValid
                                   && startMode == gsc_pkg::START_COLD) // see RULE_09
    else $error("missing backup must cold start");
  chk_warm_hot: assert property (relSeq and backupKept |=> startValid
                                 && startMode != gsc_pkg::START_COLD) // see RULE_08
    else $error("kept backup must not cold start");
  chk_frame_head: assert property (txLoad && frState == gsc_pkg::FR_HEAD
                                   |-> txByte == gsc_pkg::CH_DOLLAR ##1 isBody) // see RULE_10
    else $error("sentence must open with dollar");
  chk_tx_start: assert property (txLoad && !sysRst |=> txBusy ##1 !primarySerialOut) // see RULE_05
    else $error("start bit missing on primary output");
endmodule
`default_nettype wire

// ### gsc_host_model.sv
// Purpose: host side of the receiver serial links
// Assumes: 8N1 frames, bit time of div sys_clk cycles
// Notes:   bytes decoded from the sentence output collect in rxQ
`timescale 1ns/1ps
`default_nettype none
module gsc_host_model (
  input  wire logic sys_clk,
  input  wire logic primarySerialOut,
  output var logic  primarySerialIn,
  output var logic  secondarySerialIn
);
  int         div = 8;
  logic [7:0] rxQ[$];

  initial begin
    primarySerialIn   = 1'b1;
    secondarySerialIn = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame out on command or correction line, stop level chosen
  task automatic sendByte(input bit sec, input logic [7:0] b, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge sys_clk);
      if (sec) secondarySerialIn <= (i < 10) ? f[i] : 1'b1;
      else primarySerialIn <= (i < 10) ? f[i] : 1'b1;
      repeat (div - 1) @(posedge sys_clk);
    end
    repeat (div) @(posedge sys_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // sentence receiver, mid-bit sampling, good stop only
  always begin
    logic [7:0] b;
    @(negedge primarySerialOut);
    repeat (div / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge sys_clk);
      b[i] = primarySerialOut;
    end
    repeat (div) @(posedge sys_clk);
    if (primarySerialOut === 1'b1) rxQ.push_back(b);
  end
endmodule
`default_nettype wire

// ### tb_gps_module_host_serial_ctrl.sv
// Purpose: self-checking bench of the receiver host-side control
// Assumes: shortened pulse, divisor and outage parameters
// Notes:   host model drives and decodes the serial lines
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_gps_module_host_serial_ctrl;
  logic       sys_clk = 1'b0;
  logic       srst;
  logic       resetPinN;
  logic       supplyLow;
  logic       backupSupplyOk;
  logic       baudHighStrap;
  logic       baudLowStrap;
  logic       primarySerialIn;
  logic       secondarySerialIn;
  logic       primarySerialOut;
  logic [7:0] payloadData;
  logic       payloadValid;
  logic       payloadLast;
  logic       payloadReady;
  logic [7:0] cmdData;
  logic       cmdValid;
  logic       cmdFrameErr;
  logic [7:0] rtcmData;
  logic       rtcmValid;
  logic       rtcmFrameErr;
  logic       secondPulseOut;
  logic       coreReset;
  logic [1:0] startMode;
  logic       startValid;
  logic [1:0] baudSel;
  int         mismatches = 0;
  int         checks = 0;
  int         cycles = 0;
  int         cmdCnt = 0;
  int         cmdErrCnt = 0;
  int         rtcmCnt = 0;
  int         rtcmErrCnt = 0;

  always #10 sys_clk = ~sys_clk;

  gsc_host_serial_ctrl #(.PPS_PERIOD_CYC(100), .PPS_WIDTH_CYC(10), .DIV_4800(16),
    .DIV_9600(8), .HOT_OUTAGE_SEC(2)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .resetPinN(resetPinN), .supplyLow(supplyLow),
    .backupSupplyOk(backupSupplyOk), .baudHighStrap(baudHighStrap),
    .baudLowStrap(baudLowStrap), .primarySerialIn(primarySerialIn),
    .secondarySerialIn(secondarySerialIn), .primarySerialOut(primarySerialOut),
    .payloadData(payloadData), .payloadValid(payloadValid), .payloadLast(payloadLast),
    .payloadReady(payloadReady), .cmdData(cmdData), .cmdValid(cmdValid),
    .cmdFrameErr(cmdFrameErr), .rtcmData(rtcmData), .rtcmValid(rtcmValid),
    .rtcmFrameErr(rtcmFrameErr), .secondPulseOut(secondPulseOut), .coreReset(coreReset),
    .startMode(startMode), .startValid(startValid), .baudSel(baudSel));

  gsc_host_model i_host (
    .sys_clk(sys_clk), .primarySerialOut(primarySerialOut),
    .primarySerialIn(primarySerialIn), .secondarySerialIn(secondarySerialIn));

  //////////////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk) begin
    if (cmdValid === 1'b1) cmdCnt++;
    if (cmdFrameErr === 1'b1) cmdErrCnt++;
    if (rtcmValid === 1'b1) rtcmCnt++;
    if (rtcmFrameErr === 1'b1) rtcmErrCnt++;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic waitStart(input logic [1:0] mode, input bit pulseChk);
    int n;
    n = 0;
    while (startValid !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("startValid", 1'b1, startValid)
    `CHK("startMode", mode, startMode)
    `CHK("coreResetOff", 1'b0, coreReset)
    if (pulseChk) `CHK("pulseAtRelease", 1'b1, secondPulseOut)
    @(posedge sys_clk);
  endtask

  task automatic pinReset(input logic hi, input logic lo);
    baudHighStrap <= hi;
    baudLowStrap  <= lo;
    repeat (3) @(posedge sys_clk);
    resetPinN <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK("coreResetPin", 1'b1, coreReset)
    resetPinN <= 1'b1;
    waitStart(gsc_pkg::START_HOT, 0);
  endtask

  task automatic testStraps();
    logic [1:0] c;
    for (int i = 0; i < 5; i++) begin
      c = 2'(i % 4);
      pinReset(!c[1], !c[0]);
      `CHK("baudSel", c, baudSel)
      baudHighStrap <= c[1];
      baudLowStrap  <= c[0];
      repeat (8) @(posedge sys_clk);
      `CHK("baudSelHeld", c, baudSel)
    end
    baudHighStrap <= 1'b1;
    baudLowStrap  <= 1'b1;
  endtask

  task automatic testPulse();
    int n;
    int hi;
    int lo;
    n = 0;
    hi = 0;
    lo = 0;
    while (secondPulseOut === 1'b1 && n < 200) begin @(negedge sys_clk); n++; end
    while (secondPulseOut !== 1'b1 && n < 400) begin @(negedge sys_clk); n++; end
    while (secondPulseOut === 1'b1 && hi < 200) begin @(negedge sys_clk); hi++; end
    while (secondPulseOut !== 1'b1 && lo < 200) begin @(negedge sys_clk); lo++; end
    `CHK("pulseWidth", 10, hi)
    `CHK("pulsePeriod", 100, hi + lo)
  endtask

  function automatic logic [7:0] hexChar(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h41 + 8'(v) - 8'h0A;
  endfunction

  task automatic testSentence();
    logic [7:0] pay[3];
    logic [7:0] exp[$];
    logic [7:0] sum;
    int         n;
    pay = '{8'h47, 8'h50, 8'h5A};
    sum = 8'h00;
    i_host.div = 8;
    i_host.rxQ.delete();
    @(posedge sys_clk);
    exp.push_back(8'h24);
    for (int i = 0; i < 3; i++) begin
      payloadData  <= pay[i];
      payloadValid <= 1'b1;
      payloadLast  <= (i == 2);
      sum = sum ^ pay[i];
      exp.push_back(pay[i]);
      n = 0;
      do begin @(negedge sys_clk); n++; end while (payloadReady !== 1'b1 && n < 400);
      @(posedge sys_clk);
    end
    payloadValid <= 1'b0;
    payloadLast  <= 1'b0;
    exp.push_back(8'h2A);
    exp.push_back(hexChar(sum[7:4]));
    exp.push_back(hexChar(sum[3:0]));
    exp.push_back(8'h0D);
    exp.push_back(8'h0A);
    n = 0;
    while (i_host.rxQ.size() < 9 && n < 2000) begin @(posedge sys_clk); n++; end
    `CHK("sentenceLen", 9, i_host.rxQ.size())
    for (int i = 0; i < 9 && i < i_host.rxQ.size(); i++)
      `CHK("sentenceByte", exp[i], i_host.rxQ[i])
  endtask

  task automatic testRx();
    i_host.div = 8;
    i_host.sendByte(0, 8'hA5, 1'b1);
    `CHK("cmdCount", 1, cmdCnt)
    `CHK("cmdData", 8'hA5, cmdData)
    i_host.sendByte(1, 8'h3C, 1'b1);
    `CHK("rtcmCount", 1, rtcmCnt)
    `CHK("rtcmData", 8'h3C, rtcmData)
    i_host.sendByte(0, 8'h5A, 1'b0);
    `CHK("cmdErrCount", 1, cmdErrCnt)
    `CHK("cmdDataErr", 8'h5A, cmdData)
    pinReset(1'b1, 1'b0);
    i_host.div = 16;
    i_host.sendByte(1, 8'hC3, 1'b1);
    `CHK("rtcmData4800", 8'hC3, rtcmData)
    `CHK("rtcmCount4800", 2, rtcmCnt)
    i_host.sendByte(1, 8'h96, 1'b0);
    `CHK("rtcmErrCount", 1, rtcmErrCnt)
    `CHK("rtcmCountKept", 2, rtcmCnt)
    pinReset(1'b1, 1'b1);
  endtask

  task automatic outage(input int len, input bit lose, input logic [1:0] mode);
    supplyLow <= 1'b1;
    if (lose) backupSupplyOk <= 1'b0;
    repeat (len) @(posedge sys_clk);
    `CHK("coreResetLow", 1'b1, coreReset)
    backupSupplyOk <= 1'b1;
    repeat (5) @(posedge sys_clk);
    supplyLow <= 1'b0;
    waitStart(mode, 0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    srst           <= 1'b1;
    resetPinN      <= 1'b1;
    supplyLow      <= 1'b0;
    backupSupplyOk <= 1'b1;
    baudHighStrap  <= 1'b1;
    baudLowStrap   <= 1'b1;
    payloadData    <= 8'h00;
    payloadValid   <= 1'b0;
    payloadLast    <= 1'b0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    waitStart(gsc_pkg::START_COLD, 1);
    `CHK("baudSelReset", 2'h0, baudSel)
    testStraps();
    testPulse();
    testSentence();
    testRx();
    outage(20, 0, gsc_pkg::START_HOT);
    outage(500, 0, gsc_pkg::START_WARM);
    outage(20, 1, gsc_pkg::START_COLD);
    summarize();
  end
endmodule
`default_nettype wire
